// >>> host_model.sv
`timescale 1ns/1ps
module host_model (
   input  wire       clk,
   output reg  [3:0] reg_addr = 4'h0,
   output reg        reg_wr = 1'b0,
   output reg  [7:0] reg_wr_data = 8'h00,
   output reg        reg_rd = 1'b0,
   input  wire [7:0] reg_rd_data,
   input  wire       reg_rd_valid
);
   task xfer(input w, input [3:0] a, input [7:0] d, output [7:0] q);
      @(negedge clk);
      {reg_addr, reg_wr_data} = {a, d};
      {reg_wr, reg_rd} = {w, !w};
      @(negedge clk);
      {reg_wr, reg_rd} = 2'b00;
      reg_wr_data = ~d; // inverted so a stale byte never looks fresh
      q = reg_rd_valid ? reg_rd_data : 8'hxx;
   endtask
endmodule // host_model

// >>> isolated_switch_diag_regs.v
// Operation
// - offset 0x0 read-only summary, resets zero; bit 7 link fault, all channels off.
// - summary bit 6 is global thermal trip; it reads every channel off but does not cut output_drive.
// - summary bit 5 field supply out of range; bit 4 supply low warning.
// - summary bits 3..0 flag a fault on channel 4, 3, 2, 1.
// - offset 0x1 holds channel 2/1 overcurrent, thermal limit, open load; resets zero.
// - offset 0x2 same layout for channels 4 and 3; resets zero.
// - offset 0x3 bits 7..4 are read-only actual output states, channels 4..1.
// - offset 0x3 bits 3..0 are writable on/off commands, reset zero.
// - writing one to a clear bit clears that fault; bit 7 clears link fault.
// - parallel-input variant makes commands read-only mirrors of the parallel inputs.
// - link fault disables outputs at once until condition gone and report cleared.
// - indicator pins follow actual output state, not the commands.
`timescale 1ns/1ps
`include "switch_diag_defines.vh"

module isolated_switch_diag_regs #(
   parameter CHANNELS        = 4,
   parameter PARALLEL_INPUTS = 0
) (
   input  wire       clk,
   input  wire       rst,
   input  wire [3:0] reg_addr,
   input  wire       reg_wr,
   input  wire [7:0] reg_wr_data,
   input  wire       reg_rd,
   output reg  [7:0] reg_rd_data,
   output reg        reg_rd_valid,
   input  wire       link_fault_cond,
   input  wire       thermal_trip_cond,
   input  wire       supply_range_cond,
   input  wire       supply_low_cond,
   input  wire [3:0] overcurrent_cond,
   input  wire [3:0] thermal_limit_cond,
   input  wire [3:0] open_load_cond,
   input  wire [3:0] switch_state_in,
   input  wire [3:0] parallel_in,
   output reg  [3:0] output_drive,
   output reg  [3:0] channel_indicator_pin_out,
   output reg  [3:0] channel_indicator_pin_oe_n
);

   // filtered copies of the asynchronous pin levels
   wire       f_link;
   wire       f_thermal;
   wire       f_range;
   wire       f_low;
   wire [3:0] f_oc;
   wire [3:0] f_tlim;
   wire [3:0] f_open;
   wire [3:0] f_state;
   wire [3:0] f_parallel;

   sync_filter #(
      .W (1)
   ) u_filt_link (
      .clk      (clk),
      .rst      (rst),
      .raw      (link_fault_cond),
      .filtered (f_link)
   );

   sync_filter #(
      .W (1)
   ) u_filt_thermal (
      .clk      (clk),
      .rst      (rst),
      .raw      (thermal_trip_cond),
      .filtered (f_thermal)
   );

   sync_filter #(
      .W (1)
   ) u_filt_range (
      .clk      (clk),
      .rst      (rst),
      .raw      (supply_range_cond),
      .filtered (f_range)
   );

   sync_filter #(
      .W (1)
   ) u_filt_low (
      .clk      (clk),
      .rst      (rst),
      .raw      (supply_low_cond),
      .filtered (f_low)
   );

   sync_filter #(
      .W (4)
   ) u_filt_oc (
      .clk      (clk),
      .rst      (rst),
      .raw      (overcurrent_cond),
      .filtered (f_oc)
   );

   sync_filter #(
      .W (4)
   ) u_filt_tlim (
      .clk      (clk),
      .rst      (rst),
      .raw      (thermal_limit_cond),
      .filtered (f_tlim)
   );

   sync_filter #(
      .W (4)
   ) u_filt_open (
      .clk      (clk),
      .rst      (rst),
      .raw      (open_load_cond),
      .filtered (f_open)
   );

   sync_filter #(
      .W (4)
   ) u_filt_state (
      .clk      (clk),
      .rst      (rst),
      .raw      (switch_state_in),
      .filtered (f_state)
   );

   sync_filter #(
      .W (4)
   ) u_filt_parallel (
      .clk      (clk),
      .rst      (rst),
      .raw      (parallel_in),
      .filtered (f_parallel)
   );

   wire       clr_wr = reg_wr && (reg_addr == `ADDR_FAULT_CLEAR);
   wire [7:0] clr    = clr_wr ? reg_wr_data : 8'h00;

   wire       link_fault_flag;
   wire       global_thermal_trip;
   wire       field_supply_out_of_range;
   wire       field_supply_low_warning;
   wire [3:0] overcurrent_trip;
   wire [3:0] thermal_limit_active;
   wire [3:0] open_load_warning;
   reg  [3:0] output_command;
   reg  [3:0] actual_output_state;

   sticky_flag #(
      .W (1)
   ) u_link_flag (
      .clk   (clk),
      .rst   (rst),
      .set   (f_link),
      .clear (clr[`CLR_LINK_FAULT]),
      .flag  (link_fault_flag)
   );

   sticky_flag #(
      .W (1)
   ) u_thermal_flag (
      .clk   (clk),
      .rst   (rst),
      .set   (f_thermal),
      .clear (clr[`CLR_THERMAL_TRIP]),
      .flag  (global_thermal_trip)
   );

   sticky_flag #(
      .W (1)
   ) u_range_flag (
      .clk   (clk),
      .rst   (rst),
      .set   (f_range),
      .clear (clr[`CLR_SUPPLY_RANGE]),
      .flag  (field_supply_out_of_range)
   );

   sticky_flag #(
      .W (1)
   ) u_low_flag (
      .clk   (clk),
      .rst   (rst),
      .set   (f_low),
      .clear (clr[`CLR_SUPPLY_LOW]),
      .flag  (field_supply_low_warning)
   );

   // one clear bit covers the whole class on every channel
   sticky_flag #(
      .W (4)
   ) u_oc_flag (
      .clk   (clk),
      .rst   (rst),
      .set   (f_oc),
      .clear (clr[`CLR_OVERCURRENT]),
      .flag  (overcurrent_trip)
   );

   sticky_flag #(
      .W (4)
   ) u_tlim_flag (
      .clk   (clk),
      .rst   (rst),
      .set   (f_tlim),
      .clear (clr[`CLR_THERMAL_LIMIT]),
      .flag  (thermal_limit_active)
   );

   sticky_flag #(
      .W (4)
   ) u_open_flag (
      .clk   (clk),
      .rst   (rst),
      .set   (f_open),
      .clear (clr[`CLR_OPEN_LOAD]),
      .flag  (open_load_warning)
   );

   // output commands
   always @(posedge clk) begin
      if (rst) begin
         output_command <= `RESET_CMD4;
      end else if (PARALLEL_INPUTS != 0) begin
         output_command <= f_parallel;
      end else if (reg_wr && (reg_addr == `ADDR_OUTPUT_STATE_CMD)) begin
         output_command <= reg_wr_data[3:0];
      end
   end

   // a channel reads on only if the switch reports it on and nothing forces shutdown
   wire       all_off    = link_fault_flag | global_thermal_trip;
   wire [3:0] next_drive = output_command & ~{4{link_fault_flag}};

   always @(posedge clk) begin
      if (rst) begin
         output_drive               <= `RESET_CMD4;
         actual_output_state        <= `RESET_CMD4;
         channel_indicator_pin_out  <= 4'h0;
         channel_indicator_pin_oe_n <= 4'hF;
      end else begin
         output_drive               <= f_link ? 4'h0 : next_drive;
         actual_output_state        <= f_state & ~{4{all_off}} & output_drive;
         channel_indicator_pin_out  <= 4'h0;
         // active-low open drain: pull low (enable) while the channel is really on
         channel_indicator_pin_oe_n <= ~actual_output_state;
      end
   end

   wire [3:0] channel_fault = overcurrent_trip | thermal_limit_active | open_load_warning;

   wire [7:0] summary = {link_fault_flag, global_thermal_trip, field_supply_out_of_range,
                         field_supply_low_warning, channel_fault};
   wire [7:0] pair_low  = {overcurrent_trip[1], 1'b0, thermal_limit_active[1], open_load_warning[1],
                           overcurrent_trip[0], 1'b0, thermal_limit_active[0],
                           open_load_warning[0]};
   wire [7:0] pair_high = {overcurrent_trip[3], 1'b0, thermal_limit_active[3], open_load_warning[3],
                           overcurrent_trip[2], 1'b0, thermal_limit_active[2],
                           open_load_warning[2]};

   reg [7:0] next_rd_data;

   always @* begin
      case (reg_addr)
         `ADDR_TOP_FAULT_SUMMARY: next_rd_data = summary;
         `ADDR_FAULT_PAIR_LOW:    next_rd_data = pair_low;
         `ADDR_FAULT_PAIR_HIGH:   next_rd_data = pair_high;
         `ADDR_OUTPUT_STATE_CMD:  next_rd_data = {actual_output_state, output_command};
         default:                 next_rd_data = `RESET_REG8;
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         reg_rd_data  <= `RESET_REG8;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd;
         if (reg_rd) begin
            reg_rd_data <= next_rd_data;
         end
      end
   end

endmodule // isolated_switch_diag_regs

// three-stage pin filter: a change is accepted once stages two and three agree
module sync_filter #(
   parameter W = 1
) (
   input  wire [0:0]   clk,
   input  wire         rst,
   input  wire [W-1:0] raw,
   output reg  [W-1:0] filtered
);

   reg [W-1:0] stage1;
   reg [W-1:0] stage2;
   reg [W-1:0] stage3;

   always @(posedge clk) begin
      if (rst) begin
         stage1   <= {W{1'b0}};
         stage2   <= {W{1'b0}};
         stage3   <= {W{1'b0}};
         filtered <= {W{1'b0}};
      end else begin
         stage1   <= raw;
         stage2   <= stage1;
         stage3   <= stage2;
         // a single odd sample cannot flip the output, so one-cycle glitches are absorbed
         filtered <= (stage2 & stage3) | (filtered & (stage2 | stage3));
      end
   end

endmodule // sync_filter

// sticky report: a live condition wins over a clear in the same cycle
module sticky_flag #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         rst,
   input  wire [W-1:0] set,
   input  wire         clear,
   output reg  [W-1:0] flag
);

   always @(posedge clk) begin
      if (rst) begin
         flag <= {W{1'b0}};
      end else begin
         flag <= set | (flag & ~{W{clear}});
      end
   end

endmodule // sticky_flag

// >>> switch_diag_defines.vh
`ifndef SWITCH_DIAG_DEFINES_VH
`define SWITCH_DIAG_DEFINES_VH

// register offsets
`define ADDR_TOP_FAULT_SUMMARY 4'h0
`define ADDR_FAULT_PAIR_LOW    4'h1
`define ADDR_FAULT_PAIR_HIGH   4'h2
`define ADDR_OUTPUT_STATE_CMD  4'h3
`define ADDR_RESERVED_SLOT     4'h4
`define ADDR_FAULT_CLEAR       4'h5

// reset values
`define RESET_REG8             8'h00
`define RESET_CMD4             4'h0

// top_fault_summary field positions
`define BIT_LINK_FAULT         7
`define BIT_THERMAL_TRIP       6
`define BIT_SUPPLY_RANGE       5
`define BIT_SUPPLY_LOW         4

// fault_pair nibble field positions
`define NIB_OVERCURRENT        3
`define NIB_THERMAL_LIMIT      1
`define NIB_OPEN_LOAD          0

// fault_clear field positions
`define CLR_LINK_FAULT         7
`define CLR_THERMAL_TRIP       6
`define CLR_SUPPLY_RANGE       5
`define CLR_SUPPLY_LOW         4
`define CLR_OVERCURRENT        3
`define CLR_THERMAL_LIMIT      1
`define CLR_OPEN_LOAD          0

`endif

// >>> switch_diag_monitor.sv
`timescale 1ns/1ps
module switch_diag_monitor #(
   parameter PARALLEL_INPUTS = 0
) (
   input wire       clk,
   input wire       rst,
   input wire [3:0] reg_addr,
   input wire       reg_wr,
   input wire [7:0] reg_wr_data,
   input wire       reg_rd,
   input wire [7:0] reg_rd_data,
   input wire       reg_rd_valid,
   input wire       link_fault_cond,
   input wire [3:0] output_drive,
   input wire [3:0] channel_indicator_pin_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_read_answered: assert property (reg_rd |=> reg_rd_valid) else $error("read unanswered");
   a_valid_only_read: assert property (!reg_rd |=> !reg_rd_valid) else $error("stray valid");
   a_read_data_held: assert property (!reg_rd |=> $stable(reg_rd_data)) else $error("read data moved");
   a_unmapped_zero: assert property (reg_rd && reg_addr > 4'h3 |=> reg_rd_data == 8'h00) else $error("nonzero");
   a_reserved_slot_bits_zero: assert property (reg_rd && reg_addr inside {4'h1, 4'h2} |=> !reg_rd_data[6] && !reg_rd_data[2])
      else $error("reserved bit set");
   a_cmd_readback: assert property ((PARALLEL_INPUTS == 0 && reg_wr && reg_addr == 4'h3) ##1 !reg_wr ##1 (reg_rd && !reg_wr && reg_addr == 4'h3)
      |=> reg_rd_data[3:0] == $past(reg_wr_data[3:0], 3)) else $error("command lost");
   a_link_drive_off: assert property (link_fault_cond [*8] |-> output_drive == 4'h0) else $error("drive on");
   a_dark_when_off: assert property ((output_drive == 4'h0) [*3] |-> channel_indicator_pin_oe_n == 4'hF) else $error("lit");
   c_link: cover property (link_fault_cond [*8]);
   c_clear: cover property (reg_wr && reg_addr == 4'h5);
   c_cmd_read: cover property (reg_rd && reg_addr == 4'h3 ##1 reg_rd_valid);
endmodule // switch_diag_monitor
bind isolated_switch_diag_regs switch_diag_monitor #(.PARALLEL_INPUTS(PARALLEL_INPUTS)) u_mon (.*);

// >>> test_isolated_switch_diag_regs.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; $display("CHECK FAILED %0t got %h", $time, a); end end
module test_isolated_switch_diag_regs;
   reg        clk = 1'b0, rst = 1'b1;
   reg [19:0] cond = 20'hF_0000;
   reg [15:0] f;
   reg [7:0]  q, d;
   reg [3:0]  par_in = 4'h0;
   wire [7:0] par_rd_data;
   wire       par_rd_valid;
   wire [3:0] par_drive, par_oe_n, pin_out, par_pin_out;
   int        num_errors = 0, checks_done = 0;
   wire [3:0] reg_addr, output_drive, channel_indicator_pin_oe_n;
   wire [7:0] reg_wr_data, reg_rd_data;
   wire       reg_wr, reg_rd, reg_rd_valid;
   function [7:0] pair(input [1:0] o, input [1:0] t, input [1:0] l);
      pair = {o[1], 1'b0, t[1], l[1], o[0], 1'b0, t[0], l[0]};
   endfunction
   task print_verdict;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial forever #20 clk = ~clk;
   host_model u_host (.*);
   isolated_switch_diag_regs u_dut (.*, .link_fault_cond(cond[15]), .thermal_trip_cond(cond[14]), .supply_low_cond(cond[12]),
      .supply_range_cond(cond[13]), .overcurrent_cond(cond[3:0]), .thermal_limit_cond(cond[7:4]), .parallel_in(4'h0),
      .open_load_cond(cond[11:8]), .switch_state_in(cond[19:16]), .channel_indicator_pin_out(pin_out));
   isolated_switch_diag_regs #(.PARALLEL_INPUTS(1)) u_dut_par (.clk, .rst, .reg_addr, .reg_wr, .reg_wr_data, .reg_rd,
      .reg_rd_data(par_rd_data), .reg_rd_valid(par_rd_valid), .link_fault_cond(cond[15]), .thermal_trip_cond(cond[14]),
      .supply_range_cond(cond[13]), .supply_low_cond(cond[12]), .overcurrent_cond(cond[3:0]),
      .thermal_limit_cond(cond[7:4]), .open_load_cond(cond[11:8]), .switch_state_in(cond[19:16]), .parallel_in(par_in),
      .output_drive(par_drive), .channel_indicator_pin_out(par_pin_out), .channel_indicator_pin_oe_n(par_oe_n));
   initial begin
      #100000 num_errors++;
      print_verdict;
   end
   initial begin
      void'($urandom(32'h4de5));
      #80 rst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         u_host.xfer(1'b0, i[3:0], 8'h00, q);
         `CHK(q, 8'h00)
      end
      for (int n = 0; n < 12; n++) begin
         f = n ? 16'($urandom) : 16'hFFFF;
         {par_in, cond[19:16], d} = 16'($urandom);
         u_host.xfer(1'b1, 4'h3, d, q);
         u_host.xfer(1'b0, 4'h3, 8'h00, q);
         `CHK(q[3:0], d[3:0])
         cond[15:0] = f;
         repeat (8) @(negedge clk);
         `CHK(output_drive, f[15] ? 4'h0 : d[3:0])
         `CHK(par_drive, f[15] ? 4'h0 : par_in)
         cond[15:0] = 16'h0000;
         repeat (8) @(negedge clk);
         `CHK(output_drive, f[15] ? 4'h0 : d[3:0])
         `CHK(pin_out, 4'h0)
         u_host.xfer(1'b0, 4'h1, 8'h00, q);
         `CHK(q, pair(f[1:0], f[5:4], f[9:8]))
         u_host.xfer(1'b0, 4'h2, 8'h00, q);
         `CHK(q, pair(f[3:2], f[7:6], f[11:10]))
         u_host.xfer(1'b0, 4'h0, 8'h00, q);
         `CHK(q, {f[15:12], f[3:0] | f[7:4] | f[11:8]})
         u_host.xfer(1'b0, 4'h3, 8'h00, q);
         `CHK(q[7:4], (f[15] | f[14]) ? 4'h0 : cond[19:16] & d[3:0])
         u_host.xfer(1'b1, 4'h5, 8'hFB, q);
         repeat (8) @(negedge clk);
         u_host.xfer(1'b0, 4'h3, 8'h00, q);
         `CHK(q, {cond[19:16] & d[3:0], d[3:0]})
         `CHK(channel_indicator_pin_oe_n, ~(cond[19:16] & d[3:0]))
         `CHK(output_drive, d[3:0])
         `CHK(par_rd_data[3:0], par_in)
      end
      print_verdict;
   end
endmodule // test_isolated_switch_diag_regs
